//--- inc/mrs_map.svh
/*
 * Register map, reset values and timing counts of the reset sequencer.
 * Assumes byte addressing on a 12-bit APB address with one word per reg.
 */
`ifndef MRS_MAP_SVH
`define MRS_MAP_SVH

// Block registers (byte addresses)
`define MRS_A_STAT      12'h000
`define MRS_A_ISR       12'h004
`define MRS_A_IMR       12'h008
`define MRS_A_SFR_BASE  12'h080
`define MRS_SFR_NUM     5'h15

// Status word fields
`define MRS_ST_TO       0
`define MRS_ST_PDF      1
`define MRS_ST_RUN      2
`define MRS_ST_SYSRST   3
`define MRS_ST_WARM     4

// Interrupt status fields
`define MRS_IRQ_W       4
`define MRS_IRQ_CHIP    0
`define MRS_IRQ_WARM    1
`define MRS_IRQ_WDT     2
`define MRS_IRQ_DONE    3

// Special function register indices
`define MRS_I_TMR_CNT   5'h00
`define MRS_I_TMR_CTL   5'h01
`define MRS_I_MEM_PTR   5'h02
`define MRS_I_WORK      5'h03
`define MRS_I_TBL_PTR   5'h04
`define MRS_I_TBL_HI    5'h05
`define MRS_I_CPU_STAT  5'h06
`define MRS_I_INT_CTL   5'h07
`define MRS_I_PA_DAT    5'h08
`define MRS_I_PA_DIR    5'h09
`define MRS_I_PB_DAT    5'h0a
`define MRS_I_PB_DIR    5'h0b
`define MRS_I_PC_DAT    5'h0c
`define MRS_I_PC_DIR    5'h0d
`define MRS_I_PD_DAT    5'h0e
`define MRS_I_PD_DIR    5'h0f
`define MRS_I_PWM       5'h10
`define MRS_I_CONV_LO   5'h11
`define MRS_I_CONV_HI   5'h12
`define MRS_I_CONV_CTL  5'h13
`define MRS_I_CONV_CLK  5'h14

// Chip reset values and writable bits
`define MRS_RV_TMR_CTL  8'h08
`define MRS_RV_INT_CTL  8'h00
`define MRS_RV_PORT8    8'hff
`define MRS_RV_PORT2    8'h03
`define MRS_RV_PORT1    8'h01
`define MRS_RV_CONV_CTL 8'h40
`define MRS_RV_CONV_CLK 8'h04
`define MRS_RV_NONE     8'h00
`define MRS_WM_FULL     8'hff
`define MRS_WM_TMR_CTL  8'hdf
`define MRS_WM_SEVEN    8'h7f
`define MRS_WM_SFLAGS   8'h0f
`define MRS_WM_NONE     8'h00
`define MRS_PDF_BIT     4
`define MRS_TO_BIT      5

// Sequencing counts in system clocks
`define MRS_SST_CYCLES  11'h400
`define MRS_OPT_CYCLES  11'h010
`define MRS_CNT_ONE     11'h001
`define MRS_CNT_ZERO    11'h000

`endif

//--- inc/mrs_pkg.sv
/*
 * Types of the reset sequencer: sequencer states and reset kinds.
 * Assumes the map header is included by the design file.
 */
package mrs_pkg;

    // Sequencer state
    typedef enum logic [1:0] {
        ST_RUN,
        ST_PIN_HOLD,
        ST_OPTLOAD,
        ST_STARTUP
    } mrs_state_t;

    // What the running sequence restores
    typedef enum logic [1:0] {
        KIND_CHIP,
        KIND_WARM,
        KIND_WAKE
    } mrs_kind_t;

endpackage

//--- rtl/mrs_reset_seq.sv
/*
 * Reset sequencer of a small 8-bit controller: takes the pin, watchdog and
 * halt events, records the cause flags, runs option-load and start-up
 * delays, and holds the reset-state special registers behind APB.
 * Assumes all inputs are synchronous to mclk and rst is power-on reset.
 */
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "mrs_map.svh"

module mrs_reset_seq (
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset and wake sources
    input wire logic ext_reset_n,
    input wire logic wdt_timeout,
    input wire logic halt_mode,
    input wire logic wake_event,
    // Core instruction strobes
    input wire logic halt_exec,
    input wire logic clr_wdt_exec,
    // Reset controls to the core
    output logic sys_reset_q,
    output logic warm_reset_q,
    output logic pc_sp_clear_q,
    output logic wdt_clear_q,
    output logic cpu_run_q,
    // Interrupt
    output logic irq_q
);

    mrs_pkg::mrs_state_t state_q;
    mrs_pkg::mrs_kind_t kind_q;
    logic [10:0] cnt_q;
    logic opt_q;
    logic timeout_flag_q;
    logic powerdown_flag_q;
    logic [7:0] sfr_q [0:20];
    logic [`MRS_IRQ_W-1:0] isr_q;
    logic [`MRS_IRQ_W-1:0] imr_q;
    logic [`MRS_IRQ_W-1:0] isr_set;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic run, pin_low, busy;
    logic ev_pin_norm, ev_pin_halt, ev_wdt_norm, ev_wdt_halt, ev_wake;
    logic chip_go, seq_done;
    logic wr_en, sfr_hit;
    logic [4:0] sfr_idx;
    logic [31:0] rd_data;
    logic rd_hit;

    // Reset value of a special register under chip reset
    function automatic logic [7:0] sfr_rst_val(input logic [4:0] idx);
        case (idx)
            `MRS_I_TMR_CTL: sfr_rst_val = `MRS_RV_TMR_CTL;
            `MRS_I_INT_CTL: sfr_rst_val = `MRS_RV_INT_CTL;
            `MRS_I_PA_DAT, `MRS_I_PA_DIR,
            `MRS_I_PB_DAT, `MRS_I_PB_DIR: sfr_rst_val = `MRS_RV_PORT8;
            `MRS_I_PC_DAT, `MRS_I_PC_DIR: sfr_rst_val = `MRS_RV_PORT2;
            `MRS_I_PD_DAT, `MRS_I_PD_DIR: sfr_rst_val = `MRS_RV_PORT1;
            `MRS_I_CONV_CTL: sfr_rst_val = `MRS_RV_CONV_CTL;
            `MRS_I_CONV_CLK: sfr_rst_val = `MRS_RV_CONV_CLK;
            default: sfr_rst_val = `MRS_RV_NONE;
        endcase
    endfunction

    // Registers that a chip reset reloads; the rest keep their contents
    function automatic logic sfr_reloads(input logic [4:0] idx);
        case (idx)
            `MRS_I_TMR_CTL, `MRS_I_INT_CTL,
            `MRS_I_PA_DAT, `MRS_I_PA_DIR, `MRS_I_PB_DAT, `MRS_I_PB_DIR,
            `MRS_I_PC_DAT, `MRS_I_PC_DIR, `MRS_I_PD_DAT, `MRS_I_PD_DIR,
            `MRS_I_CONV_CTL, `MRS_I_CONV_CLK: sfr_reloads = 1'b1;
            default: sfr_reloads = 1'b0;
        endcase
    endfunction

    // Bits that software may write; unused bits read as zero
    function automatic logic [7:0] sfr_wmask(input logic [4:0] idx);
        case (idx)
            `MRS_I_TMR_CTL: sfr_wmask = `MRS_WM_TMR_CTL;
            `MRS_I_MEM_PTR, `MRS_I_INT_CTL: sfr_wmask = `MRS_WM_SEVEN;
            `MRS_I_CPU_STAT: sfr_wmask = `MRS_WM_SFLAGS;
            `MRS_I_PC_DAT, `MRS_I_PC_DIR: sfr_wmask = `MRS_RV_PORT2;
            `MRS_I_PD_DAT, `MRS_I_PD_DIR: sfr_wmask = `MRS_RV_PORT1;
            `MRS_I_CONV_CLK: sfr_wmask = `MRS_RV_CONV_CLK | `MRS_RV_PORT2;
            `MRS_I_TBL_HI, `MRS_I_CONV_LO,
            `MRS_I_CONV_HI: sfr_wmask = `MRS_WM_NONE;
            default: sfr_wmask = `MRS_WM_FULL;
        endcase
    endfunction

    // Source decode; events count only while running
    always_comb begin
        run = (state_q == mrs_pkg::ST_RUN);
        busy = !run;
        pin_low = !ext_reset_n;
        ev_pin_norm = run && pin_low && !halt_mode;
        ev_pin_halt = run && pin_low && halt_mode;
        ev_wdt_norm = run && !pin_low && wdt_timeout && !halt_mode;
        ev_wdt_halt = run && !pin_low && wdt_timeout && halt_mode;
        ev_wake = run && !pin_low && !wdt_timeout && halt_mode && wake_event;
        chip_go = ev_pin_norm || ev_pin_halt || ev_wdt_norm;
        seq_done = (state_q == mrs_pkg::ST_STARTUP) && !pin_low &&
                   (cnt_q == `MRS_CNT_ZERO);
    end

    // Sequencer; pin low at any point restarts as a chip reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= mrs_pkg::ST_OPTLOAD;
            kind_q <= mrs_pkg::KIND_CHIP;
            opt_q <= 1'b1;
            cnt_q <= `MRS_OPT_CYCLES - `MRS_CNT_ONE;
        end else begin
            case (state_q)
                mrs_pkg::ST_RUN: begin
                    if (pin_low) begin
                        state_q <= mrs_pkg::ST_PIN_HOLD;
                        kind_q <= mrs_pkg::KIND_CHIP;
                        opt_q <= !halt_mode;
                    end else if (ev_wdt_norm) begin
                        state_q <= mrs_pkg::ST_OPTLOAD;
                        kind_q <= mrs_pkg::KIND_CHIP;
                        cnt_q <= `MRS_OPT_CYCLES - `MRS_CNT_ONE;
                    end else if (ev_wdt_halt || ev_wake) begin
                        // No option load when leaving halt
                        state_q <= mrs_pkg::ST_STARTUP;
                        kind_q <= ev_wdt_halt ? mrs_pkg::KIND_WARM :
                                                mrs_pkg::KIND_WAKE;
                        cnt_q <= `MRS_SST_CYCLES - `MRS_CNT_ONE;
                    end
                end
                mrs_pkg::ST_PIN_HOLD: begin
                    if (!pin_low) begin
                        if (opt_q) begin
                            state_q <= mrs_pkg::ST_OPTLOAD;
                            cnt_q <= `MRS_OPT_CYCLES - `MRS_CNT_ONE;
                        end else begin
                            state_q <= mrs_pkg::ST_STARTUP;
                            cnt_q <= `MRS_SST_CYCLES - `MRS_CNT_ONE;
                        end
                    end
                end
                mrs_pkg::ST_OPTLOAD: begin
                    if (pin_low) begin
                        // A stale halt choice must not skip the reload
                        state_q <= mrs_pkg::ST_PIN_HOLD;
                        opt_q <= 1'b1;
                    end else if (cnt_q == `MRS_CNT_ZERO) begin
                        state_q <= mrs_pkg::ST_STARTUP;
                        cnt_q <= `MRS_SST_CYCLES - `MRS_CNT_ONE;
                    end else begin
                        cnt_q <= cnt_q - `MRS_CNT_ONE;
                    end
                end
                mrs_pkg::ST_STARTUP: begin
                    if (pin_low) begin
                        // Pin during a delay becomes a full reset
                        state_q <= mrs_pkg::ST_PIN_HOLD;
                        kind_q <= mrs_pkg::KIND_CHIP;
                        opt_q <= 1'b1;
                    end else if (cnt_q == `MRS_CNT_ZERO) begin
                        state_q <= mrs_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q - `MRS_CNT_ONE;
                    end
                end
                default: state_q <= mrs_pkg::ST_RUN;
            endcase
        end
    end

    // Core controls, one cycle behind the state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sys_reset_q <= 1'b1;
            warm_reset_q <= 1'b0;
            pc_sp_clear_q <= 1'b1;
            wdt_clear_q <= 1'b1;
            cpu_run_q <= 1'b0;
        end else begin
            sys_reset_q <= busy && (kind_q == mrs_pkg::KIND_CHIP);
            warm_reset_q <= busy && (kind_q == mrs_pkg::KIND_WARM);
            pc_sp_clear_q <= busy && (kind_q != mrs_pkg::KIND_WAKE);
            wdt_clear_q <= chip_go;
            cpu_run_q <= run;
        end
    end

    // Cause flags; hardware events are applied last so they win
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timeout_flag_q <= 1'b0;
            powerdown_flag_q <= 1'b0;
        end else begin
            if (clr_wdt_exec) begin
                timeout_flag_q <= 1'b0;
                powerdown_flag_q <= 1'b0;
            end
            if (halt_exec) begin
                timeout_flag_q <= 1'b0;
                powerdown_flag_q <= 1'b1;
            end
            if (ev_wdt_norm) begin
                timeout_flag_q <= 1'b1;
            end
            if (ev_pin_halt) begin
                timeout_flag_q <= 1'b0;
                powerdown_flag_q <= 1'b1;
            end
            if (ev_wdt_halt) begin
                timeout_flag_q <= 1'b1;
                powerdown_flag_q <= 1'b1;
            end
        end
    end

    // APB decode
    always_comb begin
        sfr_idx = paddr[6:2];
        sfr_hit = (paddr[11:7] == 5'(`MRS_A_SFR_BASE >> 7)) &&
                  (sfr_idx < `MRS_SFR_NUM);
        wr_en = psel && penable && pready_q && pwrite;
    end

    // Special registers; power-on gives every one a known value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 21; i++) begin
                sfr_q[i] <= sfr_rst_val(5'(i));
            end
        end else begin
            for (int i = 0; i < 21; i++) begin
                if (chip_go && sfr_reloads(5'(i))) begin
                    sfr_q[i] <= sfr_rst_val(5'(i));
                end else if (wr_en && sfr_hit && sfr_idx == 5'(i)) begin
                    // Pointers, results and duty simply hold otherwise
                    sfr_q[i] <= pwdata[7:0] & sfr_wmask(5'(i));
                end
            end
        end
    end

    // Read mux; status flag bits come from the cause flags
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (sfr_hit) begin
            rd_data[7:0] = sfr_q[sfr_idx];
            if (sfr_idx == `MRS_I_CPU_STAT) begin
                rd_data[`MRS_TO_BIT] = timeout_flag_q;
                rd_data[`MRS_PDF_BIT] = powerdown_flag_q;
            end
        end else begin
            case (paddr)
                `MRS_A_STAT: begin
                    rd_data[`MRS_ST_TO] = timeout_flag_q;
                    rd_data[`MRS_ST_PDF] = powerdown_flag_q;
                    rd_data[`MRS_ST_RUN] = cpu_run_q;
                    rd_data[`MRS_ST_SYSRST] = sys_reset_q;
                    rd_data[`MRS_ST_WARM] = warm_reset_q;
                end
                `MRS_A_ISR: rd_data[`MRS_IRQ_W-1:0] = isr_q;
                `MRS_A_IMR: rd_data[`MRS_IRQ_W-1:0] = imr_q;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // One wait state: data captured, then pready for one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (psel && penable && !pready_q) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
            pready_q <= 1'b1;
            pslverr_q <= !rd_hit;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Sticky events; write one to clear, a new event beats the clear
    always_comb begin
        isr_set = '0;
        isr_set[`MRS_IRQ_CHIP] = chip_go;
        isr_set[`MRS_IRQ_WARM] = ev_wdt_halt;
        isr_set[`MRS_IRQ_WDT] = ev_wdt_norm || ev_wdt_halt;
        isr_set[`MRS_IRQ_DONE] = seq_done;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            isr_q <= '0;
            imr_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wr_en && paddr == `MRS_A_ISR) begin
                isr_q <= (isr_q & ~pwdata[`MRS_IRQ_W-1:0]) | isr_set;
            end else begin
                isr_q <= isr_q | isr_set;
            end
            if (wr_en && paddr == `MRS_A_IMR) begin
                imr_q <= pwdata[`MRS_IRQ_W-1:0];
            end
            irq_q <= |(isr_q & imr_q);
        end
    end

    // Checks on the sequencer and the flags
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [10:0] sst_len_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sst_len_q <= `MRS_CNT_ZERO;
        end else if (state_q == mrs_pkg::ST_STARTUP && !pin_low) begin
            sst_len_q <= sst_len_q + `MRS_CNT_ONE;
        end else begin
            sst_len_q <= `MRS_CNT_ZERO;
        end
    end

    sequence s_halt_pin;
        run && pin_low && halt_mode;
    endsequence

    sequence s_pin_release;
        state_q == mrs_pkg::ST_PIN_HOLD && ext_reset_n && !opt_q;
    endsequence

    a_pin_chip: assert property (
        run && pin_low |=> state_q == mrs_pkg::ST_PIN_HOLD &&
        kind_q == mrs_pkg::KIND_CHIP ##1 sys_reset_q)
        else $error("pin reset did not start a chip reset");
    a_warm_only: assert property (
        ev_wdt_halt |=> kind_q == mrs_pkg::KIND_WARM ##1
        warm_reset_q && pc_sp_clear_q && !sys_reset_q)
        else $error("halt time-out was not a warm reset");
    a_por_flags: assert property (
        $past(rst) |-> !timeout_flag_q && !powerdown_flag_q)
        else $error("flags not cleared at power-up");
    a_pin_keeps: assert property (
        ev_pin_norm && !halt_exec && !clr_wdt_exec |=>
        $stable(timeout_flag_q) && $stable(powerdown_flag_q))
        else $error("normal pin reset changed the flags");
    a_wdt_to: assert property (
        ev_wdt_norm && !halt_exec && !clr_wdt_exec |=>
        timeout_flag_q && $stable(powerdown_flag_q))
        else $error("normal time-out flags wrong");
    a_wake_flags: assert property (
        s_halt_pin |=> !timeout_flag_q && powerdown_flag_q)
        else $error("pin wake flags wrong");
    a_sst_len: assert property (
        seq_done |-> sst_len_q == `MRS_SST_CYCLES - `MRS_CNT_ONE)
        else $error("start-up delay length wrong");
    a_sst_in_rst: assert property (
        state_q == mrs_pkg::ST_STARTUP && kind_q == mrs_pkg::KIND_CHIP
        |=> sys_reset_q)
        else $error("start-up delay outside reset period");
    a_no_opt_halt: assert property (
        s_halt_pin |=> !opt_q)
        else $error("option load armed after halt pin wake");
    a_skip_opt: assert property (
        s_pin_release |=> state_q == mrs_pkg::ST_STARTUP)
        else $error("option load after halt wake");
    a_reload_port: assert property (
        chip_go |=> sfr_q[`MRS_I_PA_DIR] == `MRS_RV_PORT8 &&
        sfr_q[`MRS_I_CONV_CTL] == `MRS_RV_CONV_CTL &&
        sfr_q[`MRS_I_INT_CTL] == `MRS_RV_INT_CTL)
        else $error("chip reset values not loaded");
    a_halt_pdf: assert property (
        halt_exec && !ev_wdt_norm && !ev_wdt_halt |=> powerdown_flag_q)
        else $error("halt did not set power-down flag");
    a_run_after: assert property (
        seq_done |=> run ##1 cpu_run_q && !sys_reset_q && !pc_sp_clear_q)
        else $error("core not released after delays");

endmodule

//--- sim/mrs_src_model.sv
/*
 * Model of the far side of the sequencer: the reset pin and the watchdog.
 * Assumes the bench calls its tasks from the mclk domain, one at a time.
 */
`timescale 1ns/1ps

module mrs_src_model (
    // Clock
    input wire logic mclk,
    // Reset sources
    output logic ext_reset_n,
    output logic wdt_timeout
);
    // Pin idles high, watchdog quiet
    initial begin
        ext_reset_n = 1'b1;
        wdt_timeout = 1'b0;
    end

    // Pin held low for n clocks; length is the board's choice
    task pin_reset(input int n);
        @(posedge mclk);
        ext_reset_n <= 1'b0;
        repeat (n) @(posedge mclk);
        ext_reset_n <= 1'b1;
    endtask

    // Overflow is a single-clock pulse, never held
    task wdt_fire();
        @(posedge mclk);
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
    endtask
endmodule

//--- sim/tb_top.sv
/*
 * Self-checking bench of the reset sequencer: APB master, flag and
 * register model, restart length checks.
 * Assumes the map header and the source model are compiled first.
 */
`timescale 1ns/1ps
`include "mrs_map.svh"

module tb_top;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ext_reset_n, wdt_timeout, halt_mode, wake_event, halt_exec;
    logic clr_wdt_exec, irq_q, sys_reset_q, warm_reset_q;
    logic pc_sp_clear_q, wdt_clear_q, cpu_run_q, exp_to, exp_pdf;
    int mismatches, total_checks, seed, wdt_clr_n;
    logic [31:0] snap [21];
    // Chip reset values; mask marks the reloaded ones
    logic [7:0] rv [21] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h03, 8'h01,
        8'h01, 8'h00, 8'h00, 8'h00, 8'h40, 8'h04};
    logic [20:0] rmask = 21'h18_ff82;

    mrs_reset_seq uut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n(ext_reset_n),
        .wdt_timeout(wdt_timeout), .halt_mode(halt_mode),
        .wake_event(wake_event), .halt_exec(halt_exec),
        .clr_wdt_exec(clr_wdt_exec), .sys_reset_q(sys_reset_q),
        .warm_reset_q(warm_reset_q), .pc_sp_clear_q(pc_sp_clear_q),
        .wdt_clear_q(wdt_clear_q), .cpu_run_q(cpu_run_q), .irq_q(irq_q));
    mrs_src_model src (.mclk(mclk), .ext_reset_n(ext_reset_n),
        .wdt_timeout(wdt_timeout));

    // 40 MHz clock
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // Watchdog clear pulses; the one held through power-on counts once
    always @(posedge mclk) begin
        if (!rst && wdt_clear_q === 1'b1) wdt_clr_n++;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask

    // Lengths allow a few edges of entry and exit latency
    task chk_len(input string nm, input int e, input int s);
        total_checks++;
        if (s < e - 2 || s > e + 3) begin
            mismatches++;
            $display("MISMATCH %s exp %0d seen %0d", nm, e, s);
        end
    endtask

    // APB transfer; waits for pready, no assumed latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never answers
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task sfr_rd(input int i);
        apb(1'b0, 12'h080 + 12'(4 * i), 32'h0000_0000);
    endtask

    task flags();
        apb(1'b0, `MRS_A_STAT, 32'h0000_0000);
        chk("stat_flags", {30'h0, exp_pdf, exp_to}, rd & 32'h0000_0003);
        sfr_rd(6);
        chk("cpu_flags", {26'h0, exp_to, exp_pdf, 4'h0}, rd & 32'h0000_0030);
    endtask

    // Mode 0 power-up, 1 chip reset, 2 warm reset
    task sfr_all(input int mode);
        logic [31:0] e;
        for (int i = 0; i < 21; i++) begin
            sfr_rd(i);
            e = (i == 6) ? snap[i] & 32'h0000_000f : snap[i];
            if (i == 6) rd = rd & 32'h0000_000f;
            if (mode == 2) begin
                chk("sfr_warm", e, rd);
            end else if (rmask[i]) begin
                chk("sfr_reload", {24'h0, rv[i]}, rd);
            end else if (mode == 1 && i >= 2 && i <= 6) begin
                chk("sfr_kept", e, rd);
            end
        end
    endtask

    // Counts clocks the core is held; samples the reset kind midway
    // Kind k: 0 chip reset, 1 warm reset, 2 plain wake
    task wait_seq(input string nm, input int e, input int k);
        int n;
        logic [2:0] mid;
        n = 0;
        mid = 3'bxxx;
        while (cpu_run_q !== 1'b0 && n < 4) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        while (cpu_run_q !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
            if (n == 512) mid = {sys_reset_q, warm_reset_q, pc_sp_clear_q};
        end
        chk_len(nm, e, n);
        chk("ctl_mid", {29'h0, k == 0, k == 1, k != 2}, {29'h0, mid});
    endtask

    // Core instruction and wake strobes, one clock each
    task strobe(input int k);
        @(posedge mclk);
        if (k == 0) halt_exec <= 1'b1;
        else if (k == 1) clr_wdt_exec <= 1'b1;
        else wake_event <= 1'b1;
        @(posedge mclk);
        halt_exec <= 1'b0;
        clr_wdt_exec <= 1'b0;
        wake_event <= 1'b0;
    endtask

    task results();
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is near 7000 clocks
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        results();
    end

    initial begin
        {psel, penable, pwrite, halt_mode, wake_event} = 5'h00;
        {halt_exec, clr_wdt_exec, exp_to, exp_pdf} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        seed = 98;
        rst = 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        wait_seq("powerup_len", 1040, 0);
        flags();
        sfr_all(0);
        apb(1'b1, `MRS_A_IMR, 32'h0000_0001);
        apb(1'b1, `MRS_A_ISR, 32'h0000_000f);
        repeat (3) @(posedge mclk);
        chk("irq_cleared", 32'h0, 32'(irq_q));
        for (int i = 0; i < 21; i++) begin
            apb(1'b1, 12'h080 + 12'(4 * i), $random(seed));
        end
        for (int i = 0; i < 21; i++) begin
            sfr_rd(i);
            snap[i] = rd;
        end
        // Halt, then watchdog: warm reset
        strobe(0);
        exp_pdf = 1'b1;
        flags();
        halt_mode <= 1'b1;
        src.wdt_fire();
        exp_to = 1'b1;
        wait_seq("warm_len", 1024, 1);
        flags();
        sfr_all(2);
        chk("irq_masked", 32'h0, 32'(irq_q));
        strobe(2);
        wait_seq("wake_len", 1024, 2);
        flags();
        halt_mode <= 1'b0;
        strobe(1);
        {exp_to, exp_pdf} = 2'h0;
        flags();
        // Watchdog in normal operation: chip reset
        src.wdt_fire();
        exp_to = 1'b1;
        wait_seq("wdt_len", 1040, 0);
        flags();
        sfr_all(1);
        chk("irq_set", 32'h1, 32'(irq_q));
        apb(1'b1, `MRS_A_ISR, 32'h0000_000f);
        repeat (3) @(posedge mclk);
        chk("irq_w1c", 32'h0, 32'(irq_q));
        src.pin_reset(5);
        wait_seq("pin_len", 1040, 0);
        flags();
        // Pin while halted: no option load, time-out 0, power-down 1
        strobe(0);
        {exp_to, exp_pdf} = 2'h1;
        halt_mode <= 1'b1;
        src.pin_reset(5);
        wait_seq("halt_pin_len", 1024, 0);
        flags();
        halt_mode <= 1'b0;
        // Power-on plus three chip resets, none for warm or wake
        chk("wdt_clear_cnt", 32'h0000_0004, 32'(wdt_clr_n));
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        results();
    end
endmodule
